//--- hdl/hsp_pkg.sv
package hsp_pkg;

	// Core clock period and end-of-service timing
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          EOS_TIME_NS   = 1000;
	localparam logic [7:0]  EOS_CYCLES    = 8'((EOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Register offsets on the 7-bit host address
	localparam logic [6:0]  CHANNEL_POINTER_ADDR    = 7'h01;
	localparam logic [6:0]  LOCAL_VECTOR_BASE_ADDR  = 7'h02;
	localparam logic [6:0]  REQUEST_STATUS_ADDR     = 7'h03;
	localparam logic [6:0]  END_OF_SERVICE_ADDR     = 7'h04;
	localparam logic [6:0]  SW_ACK_ADDR             = 7'h05;
	localparam logic [6:0]  TX_DATA_ADDR            = 7'h06;

	// Service types, used as index into request state
	localparam logic [1:0]  TYPE_RX    = 2'h0;
	localparam logic [1:0]  TYPE_TX    = 2'h1;
	localparam logic [1:0]  TYPE_MODEM = 2'h2;

	// Low vector codes
	localparam logic [2:0]  CODE_MODEM   = 3'h1;
	localparam logic [2:0]  CODE_TX      = 3'h2;
	localparam logic [2:0]  CODE_RX_GOOD = 3'h3;
	localparam logic [2:0]  CODE_RX_EXC  = 3'h7;

	// Reset values
	localparam logic [7:0]  VECTOR_RST  = 8'h00;
	localparam logic [1:0]  CHAN_RST    = 2'h0;

	// Host cycle sequencer, Gray along the path
	typedef enum logic [2:0] {
		HSP_IDLE = 3'b000,
		HSP_CAPT = 3'b001,
		HSP_XFER = 3'b011,
		HSP_ACK  = 3'b010
	} hsp_state_t;

	// Captured host request
	typedef struct packed {
		logic       is_ack;
		logic [1:0] ack_type;
		logic       read;
		logic [6:0] addr;
		logic [7:0] wdata;
	} hsp_req_t;

	// Vector register layout
	typedef struct packed {
		logic [4:0] base;
		logic [2:0] code;
	} hsp_vec_t;

endpackage : hsp_pkg

//--- hdl/hsp_host_port.sv
`timescale 1ns/1ps
module hsp_host_port #(
	parameter int NUM_CHANNELS = 4
) (
	input  wire logic         CORE_CLK_IN,
	input  wire logic         SYS_RST_IN,
	input  wire logic         CS_N_IN,
	input  wire logic         DATA_STROBE_N_IN,
	input  wire logic         RW_IN,
	input  wire logic [6:0]   ADDR_IN,
	input  wire logic [7:0]   DATA_IN,
	output logic      [7:0]   DATA_OUT,
	output logic              DATA_OE_OUT,
	output logic              XFER_ACK_N_OUT,
	input  wire logic         RX_SERVICE_ACK_N_IN,
	input  wire logic         TX_SERVICE_ACK_N_IN,
	input  wire logic         MODEM_SERVICE_ACK_N_IN,
	output logic      [2:0]   SERVICE_REQUEST_N_OUT,
	input  wire logic         REQ_VALID_IN,
	input  wire logic [1:0]   REQ_TYPE_IN,
	input  wire logic [1:0]   REQ_CHAN_IN,
	input  wire logic         REQ_EXCEPT_IN,
	output logic              ACK_CONTEXT_OUT,
	output logic      [1:0]   CHANNEL_POINTER_OUT,
	output logic              HOLDOFF_OUT,
	output logic      [7:0]   TX_DATA_OUT,
	output logic              TX_DATA_VALID_OUT
);
	import hsp_pkg::*;

	if (NUM_CHANNELS < 1 || NUM_CHANNELS > 4) begin : g_bad_channels
		$error("NUM_CHANNELS must be 1 to 4");
	end

	hsp_state_t   state_q;
	hsp_req_t     req_q;
	hsp_vec_t     vec_q [3];
	logic [1:0]   req_chan_q [3];
	logic [7:0]   local_vector_base_q [4];
	logic [7:0]   ram_q [512];
	logic [2:0]   pend_n_q;
	logic         div_q;
	logic         fall_en;
	logic         ctx_q;
	logic [1:0]   ctx_type_q;
	logic [1:0]   car_q;
	logic [1:0]   car_save_q;
	logic [7:0]   eos_cnt_q;
	logic         holdoff;
	logic         ack_any;
	logic [1:0]   ack_type;
	logic         start;
	logic         do_acc;
	logic         wr_acc;
	logic         ack_begin;
	logic [1:0]   ack_sel;
	logic         eos_wr;
	logic [2:0]   clr;
	logic [7:0]   rd_d;
	logic         released;

	// Divide by two; the fall of the internal clock is the sampling point
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end
	assign fall_en = div_q;

	// Decode of the selects, all active low
	assign ack_any  = ~RX_SERVICE_ACK_N_IN | ~TX_SERVICE_ACK_N_IN | ~MODEM_SERVICE_ACK_N_IN;
	assign ack_type = ~RX_SERVICE_ACK_N_IN ? TYPE_RX : (~TX_SERVICE_ACK_N_IN ? TYPE_TX : TYPE_MODEM);
	assign start    = ~DATA_STROBE_N_IN & ((~CS_N_IN) | (ack_any & RW_IN));
	assign holdoff  = eos_cnt_q != 8'h00;
	assign do_acc   = (state_q == HSP_XFER) && fall_en;
	assign wr_acc   = do_acc && !req_q.read && !req_q.is_ack;
	// Host has dropped every select; ends the cycle at a sampling point
	assign released = DATA_STROBE_N_IN && CS_N_IN && !ack_any;

	// Host cycle sequencer
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_q <= HSP_IDLE;
			req_q   <= '0;
		end else if (fall_en) begin
			case (state_q)
				HSP_IDLE: begin
					if (start && !holdoff) begin
						state_q        <= HSP_CAPT;
						req_q.is_ack   <= CS_N_IN;
						req_q.ack_type <= ack_type;
						req_q.read     <= RW_IN;
						req_q.addr     <= ADDR_IN;
					end
				end
				HSP_CAPT: begin
					state_q     <= HSP_XFER;
					req_q.wdata <= DATA_IN;
				end
				HSP_XFER: begin
					state_q <= HSP_ACK;
				end
				HSP_ACK: begin
					if (released) begin
						state_q <= HSP_IDLE;
					end
				end
				default: begin
					state_q <= HSP_IDLE;
				end
			endcase
		end
	end

	// Transfer acknowledge and data drive
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			XFER_ACK_N_OUT <= 1'b1;
			DATA_OE_OUT    <= 1'b0;
			DATA_OUT       <= 8'h00;
		end else begin
			if (do_acc) begin
				DATA_OUT    <= rd_d;
				DATA_OE_OUT <= req_q.read;
			end
			if (fall_en && state_q == HSP_ACK) begin
				if (released) begin
					XFER_ACK_N_OUT <= 1'b1;
					DATA_OE_OUT    <= 1'b0;
				end else begin
					XFER_ACK_N_OUT <= 1'b0; // Data already stands two core clock cycles
				end
			end
		end
	end

	// Read data mux, windowed by the channel pointer
	always_comb begin
		rd_d = ram_q[{car_q, req_q.addr}];
		if (req_q.is_ack) begin
			rd_d = vec_q[req_q.ack_type];
		end else begin
			case (req_q.addr)
				CHANNEL_POINTER_ADDR:   rd_d = {6'h00, car_q};
				LOCAL_VECTOR_BASE_ADDR: rd_d = local_vector_base_q[car_q];
				REQUEST_STATUS_ADDR:    rd_d = {5'h00, ~pend_n_q};
				TX_DATA_ADDR:           rd_d = 8'h00;
				default:                rd_d = ram_q[{car_q, req_q.addr}];
			endcase
		end
	end

	// Acknowledge start, by pin or by software write
	always_comb begin
		ack_sel   = req_q.ack_type;
		ack_begin = 1'b0;
		if (do_acc && req_q.is_ack) begin
			ack_begin = !ctx_q && !pend_n_q[req_q.ack_type];
		end else if (wr_acc && req_q.addr == SW_ACK_ADDR && req_q.wdata[1:0] != 2'h3) begin
			ack_sel   = req_q.wdata[1:0];
			ack_begin = !ctx_q && !pend_n_q[req_q.wdata[1:0]];
		end
	end
	assign eos_wr = wr_acc && req_q.addr == END_OF_SERVICE_ADDR;

	// Requests cleared by their acknowledge
	always_comb begin
		clr = 3'b000;
		if (ack_begin) begin
			clr[ack_sel] = 1'b1;
		end
	end

	// Request posting; a new request wins over a clear
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			pend_n_q <= 3'b111;
			for (int i = 0; i < 3; i++) begin
				vec_q[i]      <= VECTOR_RST;
				req_chan_q[i] <= CHAN_RST;
			end
		end else begin
			pend_n_q <= pend_n_q | clr;
			if (REQ_VALID_IN && REQ_TYPE_IN != 2'h3 && 32'(REQ_CHAN_IN) < NUM_CHANNELS
				&& (pend_n_q[REQ_TYPE_IN] || clr[REQ_TYPE_IN])) begin
				pend_n_q[REQ_TYPE_IN]   <= 1'b0;
				req_chan_q[REQ_TYPE_IN] <= REQ_CHAN_IN;
				vec_q[REQ_TYPE_IN].base <= local_vector_base_q[REQ_CHAN_IN][7:3];
				case (REQ_TYPE_IN)
					TYPE_RX:    vec_q[REQ_TYPE_IN].code <= REQ_EXCEPT_IN ? CODE_RX_EXC : CODE_RX_GOOD;
					TYPE_TX:    vec_q[REQ_TYPE_IN].code <= CODE_TX;
					default:    vec_q[REQ_TYPE_IN].code <= CODE_MODEM;
				endcase
			end
		end
	end

	// Context switch and channel pointer
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			ctx_q      <= 1'b0;
			ctx_type_q <= TYPE_RX;
			car_q      <= CHAN_RST;
			car_save_q <= CHAN_RST;
		end else if (ack_begin) begin
			ctx_q      <= 1'b1;
			ctx_type_q <= ack_sel;
			car_save_q <= car_q;
			car_q      <= req_chan_q[ack_sel];
		end else if (eos_wr && ctx_q) begin
			ctx_q <= 1'b0;
			car_q <= car_save_q;
		end else if (wr_acc && req_q.addr == CHANNEL_POINTER_ADDR && 32'(req_q.wdata[1:0]) < NUM_CHANNELS) begin
			car_q <= req_q.wdata[1:0];
		end
	end

	// Housekeeping hold-off after end of service
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			eos_cnt_q   <= 8'h00;
			HOLDOFF_OUT <= 1'b0;
		end else if (eos_wr) begin
			eos_cnt_q   <= EOS_CYCLES;
			HOLDOFF_OUT <= 1'b1;
		end else if (holdoff) begin
			eos_cnt_q   <= eos_cnt_q - 8'h01;
			HOLDOFF_OUT <= eos_cnt_q != 8'h01;
		end
	end

	// Register bank writes and local vector bases
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			for (int i = 0; i < 4; i++) begin
				local_vector_base_q[i] <= VECTOR_RST;
			end
		end else if (wr_acc) begin
			case (req_q.addr)
				LOCAL_VECTOR_BASE_ADDR: local_vector_base_q[car_q] <= req_q.wdata;
				CHANNEL_POINTER_ADDR, REQUEST_STATUS_ADDR, END_OF_SERVICE_ADDR,
				SW_ACK_ADDR, TX_DATA_ADDR: ;
				default:                ram_q[{car_q, req_q.addr}] <= req_q.wdata;
			endcase
		end
	end

	// Transmit data latched on every write; valid pulsed only in a transmit context
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			TX_DATA_OUT       <= 8'h00;
			TX_DATA_VALID_OUT <= 1'b0;
		end else begin
			TX_DATA_VALID_OUT <= wr_acc && req_q.addr == TX_DATA_ADDR && ctx_q && ctx_type_q == TYPE_TX;
			if (wr_acc && req_q.addr == TX_DATA_ADDR) begin
				TX_DATA_OUT <= req_q.wdata;
			end
		end
	end

	// Status outputs
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			SERVICE_REQUEST_N_OUT <= 3'b111;
			ACK_CONTEXT_OUT       <= 1'b0;
			CHANNEL_POINTER_OUT   <= CHAN_RST;
		end else begin
			SERVICE_REQUEST_N_OUT <= pend_n_q;
			ACK_CONTEXT_OUT       <= ctx_q;
			CHANNEL_POINTER_OUT   <= car_q;
		end
	end

endmodule : hsp_host_port

//--- tb/hsp_host_port_properties.sv
`timescale 1ns/1ps
module hsp_host_port_properties import hsp_pkg::*; (
	input wire logic       CORE_CLK_IN,
	input wire logic       SYS_RST_IN,
	input wire logic       CS_N_IN,
	input wire logic       DATA_STROBE_N_IN,
	input wire logic       RW_IN,
	input wire logic [6:0] ADDR_IN,
	input wire logic       XFER_ACK_N_OUT,
	input wire logic       DATA_OE_OUT,
	input wire logic       RX_SERVICE_ACK_N_IN,
	input wire logic       TX_SERVICE_ACK_N_IN,
	input wire logic       MODEM_SERVICE_ACK_N_IN,
	input wire logic [2:0] SERVICE_REQUEST_N_OUT,
	input wire logic       REQ_VALID_IN,
	input wire logic [1:0] REQ_TYPE_IN,
	input wire logic       ACK_CONTEXT_OUT,
	input wire logic       HOLDOFF_OUT,
	input wire logic       TX_DATA_VALID_OUT
);
	logic [7:0] hcnt_q;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// Counts consecutive hold-off cycles
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN || !HOLDOFF_OUT)
			hcnt_q <= 8'h00;
		else if (hcnt_q != 8'hff)
			hcnt_q <= hcnt_q + 8'h01;
	end
	a_read_drive: assert property ($fell(XFER_ACK_N_OUT) && RW_IN |-> DATA_OE_OUT && $past(DATA_OE_OUT, 2))
		else $error("read acknowledged without data driven");
	a_write_quiet: assert property ($fell(XFER_ACK_N_OUT) && !RW_IN |-> !DATA_OE_OUT)
		else $error("write cycle drives the bus");
	a_ack_hold: assert property (!XFER_ACK_N_OUT && !DATA_STROBE_N_IN |=> !XFER_ACK_N_OUT)
		else $error("acknowledge dropped while strobe held");
	a_ack_release: assert property ($rose(DATA_STROBE_N_IN) && !XFER_ACK_N_OUT |-> ##[1:3] XFER_ACK_N_OUT)
		else $error("acknowledge not removed after release");
	a_ack_timing: assert property ($fell(XFER_ACK_N_OUT) |-> !$past(DATA_STROBE_N_IN, 7)
		&& !$past(DATA_STROBE_N_IN))
		else $error("acknowledge earlier than fixed sequence");
	a_holdoff_len: assert property ($fell(HOLDOFF_OUT) |-> hcnt_q >= 8'd123 && hcnt_q <= 8'd127)
		else $error("hold-off length wrong");
	a_ack_after_wait: assert property ($fell(XFER_ACK_N_OUT) |-> !$past(HOLDOFF_OUT, 4))
		else $error("acknowledge given during hold-off");
	a_req_post: assert property (REQ_VALID_IN && REQ_TYPE_IN == TYPE_RX |-> ##2 !SERVICE_REQUEST_N_OUT[0])
		else $error("receive request not raised");
	a_ctx_cause: assert property ($rose(ACK_CONTEXT_OUT) |-> !DATA_STROBE_N_IN && (!RX_SERVICE_ACK_N_IN
		|| !TX_SERVICE_ACK_N_IN || !MODEM_SERVICE_ACK_N_IN || (!CS_N_IN && ADDR_IN == SW_ACK_ADDR)))
		else $error("context entered without acknowledge");
	a_tx_ctx: assert property (TX_DATA_VALID_OUT |-> ACK_CONTEXT_OUT && !CS_N_IN && ADDR_IN == TX_DATA_ADDR)
		else $error("transmit data outside context");
endmodule : hsp_host_port_properties
bind hsp_host_port hsp_host_port_properties hsp_host_port_properties_i (.CORE_CLK_IN(CORE_CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .CS_N_IN(CS_N_IN), .DATA_STROBE_N_IN(DATA_STROBE_N_IN), .RW_IN(RW_IN),
	.ADDR_IN(ADDR_IN), .XFER_ACK_N_OUT(XFER_ACK_N_OUT), .DATA_OE_OUT(DATA_OE_OUT),
	.RX_SERVICE_ACK_N_IN(RX_SERVICE_ACK_N_IN), .TX_SERVICE_ACK_N_IN(TX_SERVICE_ACK_N_IN),
	.MODEM_SERVICE_ACK_N_IN(MODEM_SERVICE_ACK_N_IN), .SERVICE_REQUEST_N_OUT(SERVICE_REQUEST_N_OUT),
	.REQ_VALID_IN(REQ_VALID_IN), .REQ_TYPE_IN(REQ_TYPE_IN), .ACK_CONTEXT_OUT(ACK_CONTEXT_OUT),
	.HOLDOFF_OUT(HOLDOFF_OUT), .TX_DATA_VALID_OUT(TX_DATA_VALID_OUT));

//--- tb/hsp_host_model.sv
`timescale 1ns/1ps
module hsp_host_model (
	input  wire logic       clk_in,
	input  wire logic       xfer_ack_n_in,
	input  wire logic [7:0] data_in,
	input  wire logic       data_oe_in,
	output logic            cs_n_out,
	output logic            data_strobe_n_out,
	output logic            rw_out,
	output logic [6:0]      addr_out,
	output logic [7:0]      data_out,
	output logic [2:0]      service_ack_n_out
);
	// Idle bus, all selects inactive high
	initial begin
		cs_n_out = 1'b1;
		data_strobe_n_out = 1'b1;
		service_ack_n_out = 3'h7;
		rw_out = 1'b1;
		addr_out = 7'h00;
		data_out = 8'h00;
	end
	// One byte cycle, held until the acknowledge is sampled low or 400 clocks have passed
	task automatic cycle(input logic [1:0] kind, input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q, output int waited);
		@(posedge clk_in);
		#1;
		rw_out = rd;
		addr_out = a;
		data_out = d;
		if (kind == 2'h0) cs_n_out = 1'b0;
		else service_ack_n_out[kind - 2'h1] = 1'b0;
		data_strobe_n_out = 1'b0;
		waited = 0;
		do begin
			@(posedge clk_in);
			waited++;
		end while (xfer_ack_n_in !== 1'b0 && waited < 400);
		q = (data_oe_in === 1'b1) ? data_in : 8'hxx;
		#1;
		cs_n_out = 1'b1;
		data_strobe_n_out = 1'b1;
		service_ack_n_out = 3'h7;
		data_out = ~d;
		addr_out = ~a;
		repeat (4) @(posedge clk_in);
	endtask : cycle
endmodule : hsp_host_model

//--- tb/hsp_host_port_tb_top.sv
`timescale 1ns/1ps
module hsp_host_port_tb_top;
	import hsp_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, rv = 1'b0, rx_exc = 1'b0;
	logic [1:0] rt = 2'h0, rc = 2'h0, ptr;
	logic       cs_n, strb_n, rw, oe, xack_n, ctx, hold, txv;
	logic [2:0] sack_n, sreq_n;
	logic [6:0] addr;
	logic [7:0] wd, dq, txd, rnd, q, e;
	logic [7:0] exp_q [$];
	int         mismatches = 0, cmp_count = 0, cycles = 0, vcnt = 0, n, chp, sav, t, ch;
	initial forever #4 clk = ~clk;
	hsp_host_port #(.NUM_CHANNELS(4)) hsp_host_port_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CS_N_IN(cs_n),
		.DATA_STROBE_N_IN(strb_n), .RW_IN(rw), .ADDR_IN(addr), .DATA_IN(wd), .DATA_OUT(dq), .DATA_OE_OUT(oe),
		.XFER_ACK_N_OUT(xack_n), .RX_SERVICE_ACK_N_IN(sack_n[0]), .TX_SERVICE_ACK_N_IN(sack_n[1]),
		.MODEM_SERVICE_ACK_N_IN(sack_n[2]), .SERVICE_REQUEST_N_OUT(sreq_n), .REQ_VALID_IN(rv), .REQ_TYPE_IN(rt),
		.REQ_CHAN_IN(rc), .REQ_EXCEPT_IN(rx_exc), .ACK_CONTEXT_OUT(ctx), .CHANNEL_POINTER_OUT(ptr),
		.HOLDOFF_OUT(hold), .TX_DATA_OUT(txd), .TX_DATA_VALID_OUT(txv));
	hsp_host_model hsp_host_model_i (.clk_in(clk), .xfer_ack_n_in(xack_n), .data_in(dq), .data_oe_in(oe),
		.cs_n_out(cs_n), .data_strobe_n_out(strb_n), .rw_out(rw), .addr_out(addr), .data_out(wd),
		.service_ack_n_out(sack_n));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic x, input logic g);
		chk8(nm, {7'h00, x}, {7'h00, g});
	endtask : chk1
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		hsp_host_model_i.cycle(2'h0, 1'b0, a, d, q, n);
	endtask : wr
	task automatic rd(input logic [1:0] k, input logic [6:0] a);
		hsp_host_model_i.cycle(k, 1'b1, a, 8'h00, q, n);
	endtask : rd
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Cycle ceiling and transmit pulse count
	always @(posedge clk) begin
		cycles++;
		if (txv === 1'b1) vcnt++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
		chk8("request_n", 8'h07, {5'h00, sreq_n});
		chk8("idle", 8'h81, {xack_n, oe, ctx, hold, ptr, 2'h1});
		$display("Test reset done");
		rnd = 8'h1b;
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			chp = rnd[1:0];
			wr(CHANNEL_POINTER_ADDR, rnd);
			chk1("wait", 1'b1, n >= 8 && n <= 9);
			wr(LOCAL_VECTOR_BASE_ADDR, ~rnd);
			wr({1'b1, rnd[5:0]}, rnd ^ 8'h5a);
			exp_q.push_back(8'(chp));
			exp_q.push_back(~rnd);
			exp_q.push_back(rnd ^ 8'h5a);
			rd(2'h0, CHANNEL_POINTER_ADDR);
			chk8("pointer", exp_q.pop_front(), q);
			rd(2'h0, LOCAL_VECTOR_BASE_ADDR);
			chk8("local_base", exp_q.pop_front(), q);
			rd(2'h0, {1'b1, rnd[5:0]});
			chk8("ram", exp_q.pop_front(), q);
		end
		wr(TX_DATA_ADDR, 8'h3c);
		rd(2'h0, REQUEST_STATUS_ADDR);
		chk8("status", 8'h00, q);
		$display("Test register access done");
		for (int i = 0; i < 5; i++) begin
			t = (i == 0) ? 0 : (i == 4 ? 2 : i - 1);
			rnd = lfsr(rnd);
			ch = rnd[1:0];
			wr(CHANNEL_POINTER_ADDR, 8'(ch));
			wr(LOCAL_VECTOR_BASE_ADDR, rnd);
			sav = ch ^ 1;
			wr(CHANNEL_POINTER_ADDR, 8'(sav));
			e = {rnd[7:3], t == 2 ? CODE_MODEM : t == 1 ? CODE_TX : i == 0 ? CODE_RX_EXC : CODE_RX_GOOD};
			@(posedge clk);
			#1 {rv, rt, rc, rx_exc} = {1'b1, 2'(t), 2'(ch), i == 0};
			@(posedge clk);
			#1 rv = 1'b0;
			repeat (2) @(posedge clk);
			#1;
			chk1("request_n", 1'b0, sreq_n[t]);
			rd(2'h0, REQUEST_STATUS_ADDR);
			chk8("status", 8'(1 << t), q);
			if (i == 4) wr(SW_ACK_ADDR, 8'(t));
			else rd(2'(t + 1), 7'h00);
			if (i != 4) chk8("vector", e, q);
			chk8("context_pointer", 8'(ch + 4), {5'h00, ctx, ptr});
			chk1("request_n", 1'b1, sreq_n[t]);
			if (t == 1) wr(TX_DATA_ADDR, ~rnd);
			if (t == 1) chk8("tx_data", ~rnd, txd);
			wr(END_OF_SERVICE_ADDR, rnd);
			chk8("restored", 8'(sav), {5'h00, ctx, ptr});
			chk1("holdoff", 1'b1, hold);
			rd(2'h0, CHANNEL_POINTER_ADDR);
			chk1("stretched", 1'b1, n > 110 && n < 140);
			chk8("pointer", 8'(sav), q);
		end
		// Unused request type is ignored; acknowledge with nothing pending keeps normal mode
		@(posedge clk);
		#1 {rv, rt} = 3'h7;
		@(posedge clk);
		#1 rv = 1'b0;
		rd(2'h0, REQUEST_STATUS_ADDR);
		chk8("status", 8'h00, q);
		rd(2'h1, 7'h00);
		chk8("no_context", 8'(sav), {5'h00, ctx, ptr});
		chk8("tx_pulses", 8'h01, 8'(vcnt));
		$display("Test service requests done");
		tally_and_finish();
	end
endmodule : hsp_host_port_tb_top
